/* power_mode_pkg.sv */
package power_mode_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] power_control_2_addr = 8'h00;
	localparam logic [7:0] system_options_1_addr = 8'h04;
	localparam logic [7:0] cpu_control_addr = 8'h08;
	localparam logic [7:0] pin_options_addr = 8'h0C;
	localparam logic [7:0] mode_status_addr = 8'h10;

	// power_control_2 fields
	localparam int lpr_bit = 0;
	localparam int regulator_standby_status_bit = 1;
	localparam int wake_to_full_regulation_bit = 2;
	localparam int off_select_bit = 3;
	localparam int wake_flag_bit = 4;
	localparam int release_bit = 5;
	// system_options_1 fields
	localparam int stop_allow_bit = 0;
	localparam int wait_allow_bit = 1;
	// cpu_control fields
	localparam int ird_bit = 0;
	// pin_options fields
	localparam int mux_select_bit = 0;
	localparam int pullup_bit = 1;
	localparam int rtc_enable_bit = 2;
	localparam int pin_input_bit = 3;

	// Values after reset
	localparam logic [1:0] options_reset = 2'h2;
	localparam logic cpu_control_reset = 1'b0;
	localparam logic [3:0] pin_options_reset = 4'h8;

	// Reset vector locations
	localparam logic [31:0] status_word_addr = 32'h0000_0000;
	localparam logic [31:0] program_counter_addr = 32'h0000_0004;

	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;

	typedef enum logic [3:0] {
		st_boot, st_run, st_lowpower_run, st_wait, st_lowpower_wait,
		st_power_off_stop, st_standby_stop, st_regulated_stop, st_halt
	} mode_type;

	typedef struct packed {
		logic off_select;
		logic wake_to_full_regulation;
		logic low_power_request;
	} power_ctl_type;

	typedef struct packed {
		logic wakeup_pin_is_input;
		logic rtc_wake_enable;
		logic wakeup_pin_pullup_enable;
		logic debug_pin_mux_select;
	} pin_opts_type;

endpackage

/* sync_2ff.sv */
`timescale 1ns/100ps
`default_nettype none

module sync_2ff #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= INIT;
			sync_out <= INIT;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

`default_nettype wire

/* power_mode_controller.sv */
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none

module power_mode_controller #(
	parameter int PINS = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// CPU and debug controller
	input wire logic stop_exec,
	input wire logic irq_pending,
	input wire logic cpu_halted,
	input wire logic debug_go,
	input wire logic background_cmd,
	input wire logic mem_status_cmd,
	input wire logic debug_enable_in_stop,
	input wire logic lv_detect_enable,
	input wire logic lv_detect_stop_enable,
	output logic cpu_clock_enable,
	output logic periph_clock_enable,
	output logic regulator_standby,
	output logic vector_fetch,
	output logic irq_exception_start,
	output logic illegal_reset,
	output logic illegal_exception,
	output logic stop_wait_error,
	output logic module_reset,
	// Pins and wake sources
	input wire logic debug_pin,
	input wire logic wakeup_reset_pin,
	input wire logic rtc_wake,
	input wire logic [PINS-1:0] port_drive,
	output logic [PINS-1:0] pin_drive,
	output logic wakeup_pin_pullup,
	// Clock generator
	input wire logic lowrange_osc_running,
	input wire logic internal_ref_mode,
	input wire logic ext_ref_stop_enable,
	output logic osc_enable_in_stop
);

	// ----------------------------------------------------------------
	// Reset release and synchronisers
	// ----------------------------------------------------------------
	logic rst_meta_q, rst_n;
	logic debug_pin_s, wake_pin_s, rtc_wake_s;
	logic debug_pin_prev_q;
	logic debug_fall;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	// wake inputs synchronised
	// Raw reset: pin already sampled when internal reset rises
	// Idle levels: debug pin high, wake pin high, RTC quiet
	sync_2ff #(.WIDTH(3), .INIT(3'h6)) pin_sync (
		.clk(clk_sys),
		.rst_n(resetn),
		.async_in({debug_pin, wakeup_reset_pin, rtc_wake}),
		.sync_out({debug_pin_s, wake_pin_s, rtc_wake_s})
	);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			debug_pin_prev_q <= 1'b1;
		end else begin
			debug_pin_prev_q <= debug_pin_s;
		end
	end

	// ----------------------------------------------------------------
	// Registers and state
	// ----------------------------------------------------------------
	power_mode_pkg::mode_type mode_q;
	power_mode_pkg::power_ctl_type pctl_q;
	power_mode_pkg::pin_opts_type popt_q;
	logic [1:0] options_q;
	logic ird_q;
	logic wake_flag_q, latch_hold_q, wake_to_full_regulation_at_stop_q, dbg_at_stop_q, osc_keep_q;
	logic [PINS-1:0] pin_q;
	logic wr_go, wr_release, wr_pc2, stop_go, deep_wake;
	logic [31:0] wdata_q;
	logic [7:0] awaddr_q;
	logic aw_have_q, w_have_q;
	power_mode_pkg::mode_type stop_target;
	logic stop_illegal;
	logic in_stop;
	logic lp_exit;

	assign debug_fall = debug_pin_prev_q && !debug_pin_s && !popt_q.debug_pin_mux_select;
	assign in_stop = mode_q == power_mode_pkg::st_power_off_stop
		|| mode_q == power_mode_pkg::st_standby_stop
		|| mode_q == power_mode_pkg::st_regulated_stop;
	// pin low when input, or enabled RTC
	assign deep_wake = mode_q == power_mode_pkg::st_power_off_stop
		&& ((!wake_pin_s && popt_q.wakeup_pin_is_input)
		|| (rtc_wake_s && popt_q.rtc_wake_enable));
	assign stop_go = stop_exec && (mode_q == power_mode_pkg::st_run
		|| mode_q == power_mode_pkg::st_lowpower_run);
	// low-power exits drop request
	// Otherwise run would fall straight back into lowpower_run
	assign lp_exit = mode_q == power_mode_pkg::st_lowpower_run && !stop_go
		&& (debug_fall || irq_pending && pctl_q.wake_to_full_regulation)
		|| (mode_q == power_mode_pkg::st_lowpower_wait || mode_q == power_mode_pkg::st_standby_stop)
		&& (debug_fall || irq_pending && wake_to_full_regulation_at_stop_q);

	// ----------------------------------------------------------------
	// STOP resolution
	// ----------------------------------------------------------------
	// single cycle target decision
	always_comb begin
		stop_illegal = 1'b0;
		stop_target = mode_q;
		if (!options_q[power_mode_pkg::stop_allow_bit]
			&& !options_q[power_mode_pkg::wait_allow_bit]) begin
			stop_illegal = 1'b1;
		end else if (options_q[power_mode_pkg::wait_allow_bit]) begin
			stop_target = mode_q == power_mode_pkg::st_lowpower_run
				? power_mode_pkg::st_lowpower_wait : power_mode_pkg::st_wait;
		end else if (debug_enable_in_stop
			|| (lv_detect_enable && lv_detect_stop_enable)) begin
			stop_target = power_mode_pkg::st_regulated_stop;
		end else begin
			// control bits pick the stop mode
			stop_target = pctl_q.off_select ? power_mode_pkg::st_power_off_stop
				: power_mode_pkg::st_standby_stop;
		end
	end

	// ----------------------------------------------------------------
	// Mode sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= power_mode_pkg::st_boot;
		end else begin
			case (mode_q)
				power_mode_pkg::st_boot: begin
					mode_q <= debug_pin_s ? power_mode_pkg::st_run : power_mode_pkg::st_halt;
				end
				power_mode_pkg::st_run: begin
					if (stop_go) begin
						if (!stop_illegal) begin
							mode_q <= stop_target;
						end
					end else if (pctl_q.low_power_request && !cpu_halted) begin
						mode_q <= power_mode_pkg::st_lowpower_run;
					end
				end
				power_mode_pkg::st_lowpower_run: begin
					if (stop_go) begin
						if (!stop_illegal) begin
							mode_q <= stop_target;
						end
					end else if (!pctl_q.low_power_request || debug_fall
						|| (irq_pending && pctl_q.wake_to_full_regulation)) begin
						mode_q <= power_mode_pkg::st_run;
					end
				end
				power_mode_pkg::st_wait: begin
					if (background_cmd && dbg_at_stop_q) begin
						mode_q <= power_mode_pkg::st_halt;
					end else if (irq_pending) begin
						mode_q <= power_mode_pkg::st_run;
					end
				end
				power_mode_pkg::st_lowpower_wait, power_mode_pkg::st_standby_stop: begin
					if (debug_fall) begin
						mode_q <= power_mode_pkg::st_run;
					end else if (irq_pending) begin
						mode_q <= wake_to_full_regulation_at_stop_q || !pctl_q.low_power_request
							? power_mode_pkg::st_run : power_mode_pkg::st_lowpower_run;
					end
				end
				power_mode_pkg::st_regulated_stop: begin
					if (background_cmd && dbg_at_stop_q) begin
						mode_q <= power_mode_pkg::st_halt;
					end else if (irq_pending) begin
						mode_q <= power_mode_pkg::st_run;
					end
				end
				power_mode_pkg::st_power_off_stop: begin
					if (deep_wake) begin
						mode_q <= power_mode_pkg::st_boot;
					end
				end
				power_mode_pkg::st_halt: begin
					if (debug_go) begin
						mode_q <= power_mode_pkg::st_run;
					end
				end
				default: begin
					mode_q <= power_mode_pkg::st_boot;
				end
			endcase
		end
	end

	// Flags captured when the STOP is taken
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wake_to_full_regulation_at_stop_q <= 1'b0;
			dbg_at_stop_q <= 1'b0;
			osc_keep_q <= 1'b0;
		end else if (stop_go && !stop_illegal) begin
			wake_to_full_regulation_at_stop_q <= pctl_q.wake_to_full_regulation;
			dbg_at_stop_q <= debug_enable_in_stop;
			// low-range oscillator kept unless internal reference
			osc_keep_q <= lowrange_osc_running && !internal_ref_mode;
		end
	end

	// ----------------------------------------------------------------
	// Event outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			vector_fetch <= 1'b0;
			irq_exception_start <= 1'b0;
			illegal_reset <= 1'b0;
			illegal_exception <= 1'b0;
			stop_wait_error <= 1'b0;
			module_reset <= 1'b0;
		end else begin
			vector_fetch <= mode_q == power_mode_pkg::st_boot;
			irq_exception_start <= irq_pending && (mode_q == power_mode_pkg::st_wait
				|| mode_q == power_mode_pkg::st_lowpower_wait);
			illegal_reset <= stop_go && stop_illegal && !ird_q;
			illegal_exception <= stop_go && stop_illegal && ird_q;
			// memory status commands refused in stop, wait and low-power wait
			stop_wait_error <= mem_status_cmd && (in_stop
				|| mode_q == power_mode_pkg::st_wait || mode_q == power_mode_pkg::st_lowpower_wait);
			// RTC is not on this reset
			module_reset <= deep_wake;
		end
	end

	// CPU clock only in run, lowpower_run and halt
	assign cpu_clock_enable = mode_q == power_mode_pkg::st_run
		|| mode_q == power_mode_pkg::st_lowpower_run || mode_q == power_mode_pkg::st_halt;
	assign periph_clock_enable = !in_stop && mode_q != power_mode_pkg::st_boot;

	// ----------------------------------------------------------------
	// Regulator and pins
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			regulator_standby <= 1'b0;
			wakeup_pin_pullup <= 1'b0;
			osc_enable_in_stop <= 1'b0;
		end else begin
			regulator_standby <= !debug_enable_in_stop && (mode_q == power_mode_pkg::st_lowpower_run
				|| mode_q == power_mode_pkg::st_lowpower_wait
				|| mode_q == power_mode_pkg::st_standby_stop
				|| mode_q == power_mode_pkg::st_power_off_stop);
			wakeup_pin_pullup <= mode_q == power_mode_pkg::st_power_off_stop
				&& popt_q.wakeup_pin_pullup_enable;
			osc_enable_in_stop <= ext_ref_stop_enable || osc_keep_q;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			latch_hold_q <= 1'b0;
			wake_flag_q <= 1'b0;
		end else begin
			// hold until the release write, set wins
			if (stop_go && !stop_illegal && stop_target == power_mode_pkg::st_power_off_stop) begin
				latch_hold_q <= 1'b1;
			end else if (wr_release) begin
				latch_hold_q <= 1'b0;
			end
			if (deep_wake) begin
				wake_flag_q <= 1'b1;
			end else if (wr_release) begin
				wake_flag_q <= 1'b0;
			end
		end
	end

	// pins follow current drive once opened
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_q <= '0;
		end else if (!latch_hold_q) begin
			pin_q <= port_drive;
		end
	end
	assign pin_drive = pin_q;

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready = !w_have_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
	assign wr_pc2 = wr_go && awaddr_q == power_mode_pkg::power_control_2_addr;
	assign wr_release = wr_pc2 && wdata_q[power_mode_pkg::release_bit];

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= power_mode_pkg::resp_okay;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= awaddr_q > power_mode_pkg::mode_status_addr
					|| awaddr_q[1:0] != 2'h0 ? power_mode_pkg::resp_slverr
					: power_mode_pkg::resp_okay;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Power control survives the deep stop restart; the rest does not
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			// system reset clears the low-power request; module_reset does not
			pctl_q <= '0;
		end else if (lp_exit) begin
			pctl_q.low_power_request <= 1'b0;
		end else if (wr_pc2) begin
			pctl_q <= {wdata_q[power_mode_pkg::off_select_bit],
				wdata_q[power_mode_pkg::wake_to_full_regulation_bit], wdata_q[power_mode_pkg::lpr_bit]};
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			options_q <= power_mode_pkg::options_reset;
			ird_q <= power_mode_pkg::cpu_control_reset;
			popt_q <= power_mode_pkg::pin_options_reset;
		end else if (module_reset) begin
			// module registers reset on deep stop wake
			options_q <= power_mode_pkg::options_reset;
			ird_q <= power_mode_pkg::cpu_control_reset;
			popt_q <= power_mode_pkg::pin_options_reset;
		end else if (wr_go && awaddr_q == power_mode_pkg::system_options_1_addr) begin
			options_q <= wdata_q[1:0];
		end else if (wr_go && awaddr_q == power_mode_pkg::cpu_control_addr) begin
			ird_q <= wdata_q[power_mode_pkg::ird_bit];
		end else if (wr_go && awaddr_q == power_mode_pkg::pin_options_addr) begin
			popt_q <= wdata_q[3:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= power_mode_pkg::resp_okay;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= power_mode_pkg::resp_okay;
			s_axi_rdata <= 32'h0000_0000;
			case (s_axi_araddr)
				power_mode_pkg::power_control_2_addr: begin
					s_axi_rdata[5:0] <= {1'b0, wake_flag_q, pctl_q.off_select,
						pctl_q.wake_to_full_regulation, regulator_standby,
						pctl_q.low_power_request};
				end
				power_mode_pkg::system_options_1_addr: begin
					s_axi_rdata[1:0] <= options_q;
				end
				power_mode_pkg::cpu_control_addr: begin
					s_axi_rdata[0] <= ird_q;
				end
				power_mode_pkg::pin_options_addr: begin
					s_axi_rdata[3:0] <= popt_q;
				end
				power_mode_pkg::mode_status_addr: begin
					s_axi_rdata[3:0] <= mode_q;
				end
				default: begin
					s_axi_rresp <= power_mode_pkg::resp_slverr;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence stop_illegal_s;
		stop_go && stop_illegal;
	endsequence

	boot_select_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode_q == power_mode_pkg::st_boot |=> mode_q == (debug_pin_s ?
			power_mode_pkg::st_run : power_mode_pkg::st_halt))
		else $error("boot mode not chosen from debug pin");
	vector_fetch_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode_q == power_mode_pkg::st_boot |=> vector_fetch)
		else $error("no vector fetch after reset");
	lowpower_run_refuse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode_q == power_mode_pkg::st_run && cpu_halted |=> mode_q != power_mode_pkg::st_lowpower_run)
		else $error("lowpower_run entered while halted");
	lowpower_run_irq_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode_q == power_mode_pkg::st_lowpower_run && !stop_go && irq_pending
		&& pctl_q.wake_to_full_regulation |=> mode_q == power_mode_pkg::st_run)
		else $error("interrupt did not end lowpower_run");
	wait_clock_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode_q == power_mode_pkg::st_wait |-> !cpu_clock_enable && periph_clock_enable)
		else $error("wait clocking wrong");
	illegal_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		stop_illegal_s |=> (illegal_reset != illegal_exception) && $stable(mode_q))
		else $error("illegal STOP not reported");
	deep_latch_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		latch_hold_q && !wr_release |=> latch_hold_q)
		else $error("pin latch dropped without release");
	deep_wake_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		deep_wake |=> module_reset && wake_flag_q ##1 vector_fetch)
		else $error("deep stop wake not like power-on");
	pullup_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wakeup_pin_pullup |-> popt_q.wakeup_pin_pullup_enable || $past(popt_q.wakeup_pin_pullup_enable))
		else $error("pullup without enable");
	forced_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		stop_go && !stop_illegal && !options_q[power_mode_pkg::wait_allow_bit]
		&& debug_enable_in_stop |=> mode_q == power_mode_pkg::st_regulated_stop)
		else $error("debug enable did not force regulated_stop");

endmodule

`default_nettype wire

/* far_side.sv */
`timescale 1ns/100ps
`default_nettype none
module far_side (
	// Clock and wake answer
	input wire logic clk_sys,
	input wire logic irq_exception_start,
	// Core requests
	output logic stop_exec = 1'b0,
	output logic irq_pending = 1'b0
);
	task automatic stop();
		@(posedge clk_sys);
		stop_exec <= 1'b1;
		@(posedge clk_sys);
		stop_exec <= 1'b0;
	endtask
	task automatic irq();
		int n;
		@(posedge clk_sys);
		irq_pending <= 1'b1;
		for (n = 0; n < 50 && irq_exception_start !== 1'b1; n++)
			@(posedge clk_sys);
		irq_pending <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic clk_sys = 1'b0, resetn = 1'b0, cpu_halted = 1'b0, debug_go = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, background_cmd = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, port_drive = 8'h00, p;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic mem_status_cmd = 1'b0, debug_enable_in_stop = 1'b0, debug_pin = 1'b1;
	logic wakeup_reset_pin = 1'b1, rtc_wake = 1'b0, lowrange_osc_running = 1'b1;
	logic lv_detect_enable = 1'b0, lv_detect_stop_enable = 1'b0;
	logic internal_ref_mode = 1'b0, ext_ref_stop_enable = 1'b0;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic [7:0] pin_drive;
	wire logic stop_exec, irq_pending, cpu_clock_enable, periph_clock_enable;
	wire logic regulator_standby, vector_fetch, irq_exception_start, illegal_reset;
	wire logic illegal_exception, stop_wait_error, module_reset, wakeup_pin_pullup;
	wire logic osc_enable_in_stop;
	int n_fail = 0, checks_done = 0, cyc = 0;
	int nvf = 0, nir = 0, nie = 0, nex = 0, nse = 0, nmr = 0;

	power_mode_controller dut (.*);
	far_side far (.*);

	initial forever #50 clk_sys = ~clk_sys;
	// Pulse tallies; timeout cuts a hang
	always @(posedge clk_sys) begin
		port_drive <= 8'($urandom);
		nvf <= nvf + vector_fetch;
		nir <= nir + illegal_reset;
		nie <= nie + illegal_exception;
		nex <= nex + irq_exception_start;
		nse <= nse + stop_wait_error;
		nmr <= nmr + module_reset;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end

	task automatic chk(input string n, input logic [35:0] s, input logic [35:0] e);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic results();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", s_axi_bresp, 0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk("read", {s_axi_rresp, s_axi_rdata}, {r, e});
	endtask
	// Let synchronisers settle, then read the mode
	task automatic md(input logic [3:0] m);
		repeat (6) @(posedge clk_sys);
		rd(8'h10, {28'h0, m}, 2'h0);
	endtask

	initial begin
		void'($urandom(32'ha50b36b5));
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		md(4'h1);
		chk("vfetch", nvf, 1);
		rd(8'h04, 2, 0);
		rd(8'h08, 0, 0);
		rd(8'h0C, 8, 0);
		rd(8'h40, 0, 2);
		far.stop();
		md(4'h3);
		chk("cpuclk", cpu_clock_enable, 0);
		chk("perclk", periph_clock_enable, 1);
		far.irq();
		md(4'h1);
		chk("irqexc", nex, 1);
		wr(8'h04, 0);
		wr(8'h08, 1);
		far.stop();
		repeat (3) @(posedge clk_sys);
		chk("illexc", nie, 1);
		wr(8'h08, 0);
		far.stop();
		md(4'h1);
		chk("illrst", nir, 1);
		wr(8'h04, 1);
		wr(8'h00, 8);
		debug_enable_in_stop <= 1'b1;
		far.stop();
		md(4'h7);
		mem_status_cmd <= 1'b1;
		@(posedge clk_sys);
		mem_status_cmd <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk("swerr", nse, 1);
		background_cmd <= 1'b1;
		@(posedge clk_sys);
		background_cmd <= 1'b0;
		md(4'h8);
		debug_go <= 1'b1;
		@(posedge clk_sys);
		debug_go <= 1'b0;
		debug_enable_in_stop <= 1'b0;
		md(4'h1);
		// debug enable in stop off before request
		wr(8'h00, 1);
		md(4'h2);
		chk("stby", regulator_standby, 1);
		wr(8'h00, 0);
		rd(8'h00, 0, 0);
		wr(8'h00, 1);
		md(4'h2);
		debug_pin <= 1'b0;
		md(4'h1);
		debug_pin <= 1'b1;
		rd(8'h00, 0, 0);
		wr(8'h04, 2);
		wr(8'h00, 5);
		md(4'h2);
		far.stop();
		md(4'h4);
		far.irq();
		md(4'h1);
		chk("stby", regulator_standby, 0);
		wr(8'h04, 1);
		wr(8'h00, 8);
		far.stop();
		repeat (4) @(posedge clk_sys);
		p = pin_drive;
		repeat (8) @(posedge clk_sys);
		chk("pins", pin_drive, p);
		chk("osc", osc_enable_in_stop, 1);
		chk("pullup", wakeup_pin_pullup, 0);
		wakeup_reset_pin <= 1'b0;
		repeat (4) @(posedge clk_sys);
		wakeup_reset_pin <= 1'b1;
		md(4'h1);
		chk("modrst", nmr, 1);
		chk("vfetch", nvf, 2);
		rd(8'h00, 8'h18, 0);
		wr(8'h00, 8'h20);
		rd(8'h00, 0, 0);
		@(posedge clk_sys);
		p = port_drive;
		@(posedge clk_sys);
		chk("pins", pin_drive, p);
		cpu_halted <= 1'b1;
		wr(8'h00, 1);
		repeat (6) @(posedge clk_sys);
		chk("stby", regulator_standby, 0);
		cpu_halted <= 1'b0;
		md(4'h2);
		far.stop();
		md(4'h4);
		far.irq();
		md(4'h2);
		far.stop();
		md(4'h4);
		debug_pin <= 1'b0;
		md(4'h1);
		debug_pin <= 1'b1;
		rd(8'h00, 0, 0);
		wr(8'h00, 1);
		md(4'h2);
		far.stop();
		md(4'h4);
		resetn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		md(4'h1);
		rd(8'h00, 0, 0);
		results();
	end
endmodule
`default_nettype wire
